// file: usb_endpoint_buffer_descriptors.sv
// Operation
// - endpoint slot is 8 local bytes, 16 cpu
// - entries at local 0,2,4,6 / cpu 0,4,8,12
// - transmit start taken from bits 15..1 (only bits 8..1 used)
// - send exactly transmit length bits 9..0
// - double buffered IN uses two length entries
// - receive data stored from receive start
// - received byte count written into bits 9..0
// - bit 15 picks 2 or 32 byte blocks
// - small blocks: count times two, zero illegal
// - large blocks: (count+1)*32, 16 up reserved
// - double buffered OUT uses two receive entries
//
`timescale 1ns/1ps
`default_nettype none
`include "usb_desc_consts.svh"

module usb_endpoint_buffer_descriptors (
   input  wire logic                      clock_in,
   input  wire logic                      rst_in,
   input  wire logic                      ce_in,
   input  wire logic [15:0]               descriptor_table_base_in,
   input  wire logic                      tok_valid_in,
   input  wire usb_desc_pkg::token_kind_t tok_kind_in,
   input  wire logic [2:0]                tok_ep_in,
   input  wire logic                      tok_double_in,
   input  wire logic                      tok_second_in,
   output logic                           tok_ready_out,
   input  wire logic [7:0]                rx_data_in,
   input  wire logic                      rx_valid_in,
   input  wire logic                      rx_last_in,
   output logic                           rx_ready_out,
   output logic [7:0]                     tx_data_out,
   output logic                           tx_valid_out,
   input  wire logic                      tx_ready_in,
   output logic                           done_out,
   output logic                           rx_overflow_out,
   output logic                           rx_size_error_out,
   input  wire logic                      cpu_req_in,
   input  wire logic                      cpu_we_in,
   input  wire logic [9:0]                cpu_addr_in,
   input  wire logic [15:0]               cpu_wdata_in,
   output logic                           cpu_ack_out,
   output logic [31:0]                    cpu_rdata_out
);
   import usb_desc_pkg::*;

   logic [15:0]         mem [`PMA_WORDS];
   eng_state_t          state;
   token_kind_t         kind;
   logic [`PMA_AW-1:0]  entry_idx;
   logic [`PMA_AW-1:0]  base_idx;
   logic [`PMA_AW-1:0]  slot_off;
   logic [`PMA_AW:0]    ptr;
   logic [`PMA_AW:0]    start;
   logic [`LEN_W-1:0]   len;
   logic [`LEN_W-1:0]   rx_cnt;
   logic [10:0]         rx_size;
   logic [10:0]         dec_size;
   logic                dec_bad;
   logic [`PMA_AW-1:0]  eng_idx;
   logic [15:0]         mem_rd;
   logic                eng_we;
   logic [1:0]          eng_be;
   logic [15:0]         eng_wdata;
   logic                rx_take;
   logic                rx_room;
   logic                fifo_in_ready;
   logic                fifo_push;
   logic [7:0]          tx_byte;
   logic                cpu_grant;
   logic [`LEN_W-1:0]   tx_target;
   logic [`LEN_W-1:0]   tx_pushed;

   // ----------------------------------------
   // slot and entry addressing
   // ----------------------------------------
   assign base_idx = {descriptor_table_base_in[8:3], 2'b00};
   always_comb begin
      if (tok_double_in) begin
         slot_off = tok_second_in ? `OFF_SECOND_START : `OFF_FIRST_START;
      end else begin
         slot_off = (tok_kind_in == TOKEN_IN) ? `OFF_FIRST_START : `OFF_SECOND_START;
      end
   end

   always_comb begin
      case (state)
         ST_FETCH_START: eng_idx = entry_idx;
         ST_FETCH_LEN:   eng_idx = entry_idx + `OFF_LENGTH;
         ST_WRBACK:      eng_idx = entry_idx + `OFF_LENGTH;
         default:        eng_idx = ptr[`PMA_AW:1];
      endcase
   end
   assign mem_rd = mem[eng_idx];

   rx_size_decode u_size (
      .granularity_in (mem_rd[`GRAN_BIT]),
      .quantity_in    (mem_rd[`QTY_MSB:`QTY_LSB]),
      .size_out       (dec_size),
      .bad_out        (dec_bad)
   );

   // ----------------------------------------
   // engine sequencing
   // ----------------------------------------
   assign rx_take   = (state == ST_RX_DATA) & rx_valid_in & rx_ready_out;
   assign rx_room   = ({1'b0, rx_cnt} < rx_size);
   assign fifo_push = (state == ST_TX_BYTE);
   assign tx_byte   = ptr[0] ? mem_rd[15:8] : mem_rd[7:0];

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state             <= ST_IDLE;
         kind              <= TOKEN_IN;
         entry_idx         <= '0;
         ptr               <= '0;
         start             <= '0;
         len               <= '0;
         rx_cnt            <= '0;
         rx_size           <= '0;
         tok_ready_out     <= 1'b1;
         rx_ready_out      <= 1'b0;
         done_out          <= 1'b0;
         rx_overflow_out   <= 1'b0;
         rx_size_error_out <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (tok_valid_in) begin
                  kind          <= tok_kind_in;
                  entry_idx     <= 8'(base_idx + {tok_ep_in, 2'b00} + slot_off);
                  tok_ready_out <= 1'b0;
                  state         <= ST_FETCH_START;
               end
            end
            ST_FETCH_START: begin
               ptr   <= {mem_rd[`PMA_AW:1], 1'b0};
               start <= {mem_rd[`PMA_AW:1], 1'b0};
               state <= ST_FETCH_LEN;
            end
            ST_FETCH_LEN: begin
               if (kind == TOKEN_IN) begin
                  len   <= mem_rd[`LEN_MSB:0];
                  state <= (mem_rd[`LEN_MSB:0] == '0) ? ST_FINISH : ST_TX_BYTE;
               end else begin
                  rx_size           <= dec_size;
                  rx_size_error_out <= dec_bad;
                  rx_overflow_out   <= 1'b0;
                  rx_cnt            <= '0;
                  rx_ready_out      <= 1'b1;
                  state             <= ST_RX_DATA;
               end
            end
            ST_TX_BYTE: begin
               if (fifo_in_ready) begin
                  ptr <= ptr + 1'b1;
                  len <= len - 1'b1;
                  if (len == `LEN_W'(1)) begin
                     state <= ST_FINISH;
                  end
               end
            end
            ST_RX_DATA: begin
               if (rx_take) begin
                  ptr <= ptr + 1'b1;
                  if (rx_cnt != `LEN_MAX) begin
                     rx_cnt <= rx_cnt + 1'b1;
                  end
                  if (!rx_room) begin
                     rx_overflow_out <= 1'b1;
                  end
                  if (rx_last_in) begin
                     rx_ready_out <= 1'b0;
                     state        <= ST_WRBACK;
                  end
               end
            end
            ST_WRBACK: begin
               state <= ST_FINISH;
            end
            ST_FINISH: begin
               done_out      <= 1'b1;
               tok_ready_out <= 1'b1;
               state         <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // packet memory, engine has priority
   // ----------------------------------------
   always_comb begin
      eng_we    = 1'b0;
      eng_be    = 2'b00;
      eng_wdata = {rx_data_in, rx_data_in};
      if (rx_take && rx_room) begin
         eng_we = 1'b1;
         eng_be = ptr[0] ? 2'b10 : 2'b01;
      end else if (state == ST_WRBACK) begin
         eng_we    = 1'b1;
         eng_be    = 2'b11;
         eng_wdata = {mem_rd[15:`LEN_W], rx_cnt};
      end
   end

   assign cpu_grant = cpu_req_in & ~cpu_ack_out & ~(cpu_we_in & eng_we);

   always_ff @(posedge clock_in) begin
      if (ce_in) begin
         if (eng_we) begin
            for (int b = 0; b < `HALF_WORD_BYTES; b++) begin
               if (eng_be[b]) begin
                  mem[eng_idx][b*8 +: 8] <= eng_wdata[b*8 +: 8];
               end
            end
         end else if (cpu_grant && cpu_we_in) begin
            mem[cpu_addr_in[`CPU_AW-1:2]] <= cpu_wdata_in;
         end
      end
   end

   // ----------------------------------------
   // cpu port, one halfword per 32-bit word
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_ack_out   <= 1'b0;
         cpu_rdata_out <= 32'h0000_0000;
      end else if (ce_in) begin
         cpu_ack_out <= cpu_grant;
         if (cpu_grant && !cpu_we_in) begin
            cpu_rdata_out <= {16'h0000, mem[cpu_addr_in[`CPU_AW-1:2]]};
         end
      end
   end

   // ----------------------------------------
   // transmit fifo
   // ----------------------------------------
   desc_byte_fifo #(
      .WIDTH (`BYTE_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (fifo_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (tx_byte),
      .out_valid_out (tx_valid_out),
      .out_ready_in  (tx_ready_in),
      .out_data_out  (tx_data_out)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tx_target <= '0;
         tx_pushed <= '0;
      end else if (ce_in) begin
         if (state == ST_FETCH_LEN) begin
            tx_target <= mem_rd[`LEN_MSB:0];
            tx_pushed <= '0;
         end else if (fifo_push && fifo_in_ready) begin
            tx_pushed <= tx_pushed + 1'b1;
         end
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_slot_entry;
      (state == ST_IDLE && tok_valid_in && ce_in) |=>
         entry_idx == 8'($past(base_idx) + {$past(tok_ep_in), 2'b00} + $past(slot_off));
   endproperty
   a_slot_entry: assert property (p_slot_entry) else $error("slot entry index wrong");

   property p_tx_start;
      (state == ST_FETCH_START && ce_in) |=> ptr == {$past(mem_rd[`PMA_AW:1]), 1'b0};
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("buffer start not taken from entry");

   property p_tx_exact;
      (state == ST_FINISH && kind == TOKEN_IN) |-> tx_pushed == tx_target;
   endproperty
   a_tx_exact: assert property (p_tx_exact) else $error("transmit byte total differs from length");

   property p_rx_first;
      (rx_take && rx_cnt == '0) |-> eng_idx == start[`PMA_AW:1];
   endproperty
   a_rx_first: assert property (p_rx_first) else $error("first byte not at receive start");

   property p_rx_count;
      (state == ST_WRBACK && ce_in) |=> mem[$past(eng_idx)][`LEN_MSB:0] == $past(rx_cnt) ##1 done_out;
   endproperty
   a_rx_count: assert property (p_rx_count) else $error("received count not written back");

   property p_size_small;
      (!mem_rd[`GRAN_BIT] && mem_rd[`QTY_MSB:`QTY_LSB] != 5'h00) |->
         dec_size == {5'h00, mem_rd[`QTY_MSB:`QTY_LSB], 1'b0} && !dec_bad;
   endproperty
   a_size_small: assert property (p_size_small) else $error("small block size wrong");

   property p_size_large;
      (mem_rd[`GRAN_BIT] && mem_rd[14] == 1'b0) |->
         dec_size == {1'b0, 5'(mem_rd[13:10] + 4'h0) + 5'h01, 5'h00} && !dec_bad;
   endproperty
   a_size_large: assert property (p_size_large) else $error("large block size wrong");

   property p_no_overrun;
      (eng_we && state == ST_RX_DATA) |-> ({1'b0, rx_cnt} < rx_size);
   endproperty
   a_no_overrun: assert property (p_no_overrun) else $error("write beyond receive buffer");

   property p_fetch_order;
      (state == ST_FETCH_START && ce_in) |=> state == ST_FETCH_LEN;
   endproperty
   a_fetch_order: assert property (p_fetch_order) else $error("entries not fetched in order");

   c_in_done:  cover property (state == ST_FINISH && kind == TOKEN_IN && tx_target != '0);
   c_out_done: cover property (state == ST_WRBACK && kind == TOKEN_OUT);
   c_overflow: cover property (rx_take && !rx_room);
   c_cpu_hold: cover property (cpu_req_in && cpu_we_in && eng_we);

endmodule

`default_nettype wire

// file: usb_desc_consts.svh
`ifndef USB_DESC_CONSTS_SVH
`define USB_DESC_CONSTS_SVH

// ----------------------------------------
// packet memory geometry
// ----------------------------------------
`define PMA_AW            8
`define PMA_WORDS         256
`define CPU_AW            10
`define SLOT_SHIFT        2
`define HALF_WORD_BYTES   2

// ----------------------------------------
// entry offsets, halfword index inside a slot (cpu offsets 0, 4, 8, 12)
// ----------------------------------------
`define OFF_FIRST_START   8'h00
`define OFF_SECOND_START  8'h02
`define OFF_LENGTH        8'h01

// ----------------------------------------
// entry fields
// ----------------------------------------
`define LEN_MSB           9
`define LEN_W             10
`define GRAN_BIT          15
`define QTY_MSB           14
`define QTY_LSB           10
`define SMALL_BLOCK_SHIFT 1
`define LARGE_BLOCK_SHIFT 5
`define QTY_LARGE_LIMIT   5'h10
`define LEN_MAX           10'h3ff

// ----------------------------------------
// data path
// ----------------------------------------
`define BYTE_W            8
`define FIFO_DEPTH        4

`endif

// file: usb_desc_pkg.sv
package usb_desc_pkg;

   typedef enum logic [1:0] {
      TOKEN_IN,
      TOKEN_OUT,
      TOKEN_SETUP
   } token_kind_t;

   typedef enum {
      ST_IDLE,
      ST_FETCH_START,
      ST_FETCH_LEN,
      ST_TX_BYTE,
      ST_RX_DATA,
      ST_WRBACK,
      ST_FINISH
   } eng_state_t;

endpackage

// file: rx_size_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_desc_consts.svh"

module rx_size_decode (
   input  wire logic        granularity_in,
   input  wire logic [4:0]  quantity_in,
   output logic      [10:0] size_out,
   output logic             bad_out
);

   always_comb begin
      if (granularity_in) begin
         size_out = 11'(({6'h00, quantity_in} + 11'h001) << `LARGE_BLOCK_SHIFT);
         bad_out  = (quantity_in >= `QTY_LARGE_LIMIT);
      end else begin
         size_out = 11'({6'h00, quantity_in} << `SMALL_BLOCK_SHIFT);
         bad_out  = (quantity_in == 5'h00);
      end
      if (bad_out) begin
         size_out = 11'h000;
      end
   end

endmodule

`default_nettype wire

// file: desc_byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module desc_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   logic [PW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready_out = (count != (PW+1)'(DEPTH));
   assign push         = in_valid_in & in_ready_out & ce_in;
   assign pop          = out_valid_out & out_ready_in & ce_in;
   assign out_data_out = store[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         count         <= '0;
         out_valid_out <= 1'b0;
         wr_ptr        <= '0;
         rd_ptr        <= '0;
      end else begin
         count         <= next_count;
         out_valid_out <= (next_count != '0);
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (push) begin
         store[wr_ptr] <= in_data_in;
      end
   end

endmodule

`default_nettype wire

// file: usb_line_partner.sv
`timescale 1ns/1ps
`default_nettype none

module usb_line_partner (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic [1:0]  mode_in,
   input  wire logic        go_in,
   input  wire logic [10:0] len_in,
   input  wire logic [7:0]  first_in,
   input  wire logic [7:0]  tx_data_in,
   input  wire logic        tx_valid_in,
   output logic             tx_ready_out,
   input  wire logic        rx_ready_in,
   output logic [7:0]       rx_data_out,
   output logic             rx_valid_out,
   output logic             rx_last_out
);
   // ----------------------------------------
   // serial engine line side
   // ----------------------------------------
   // mode 0 prompt, 1 random stalls, 2 transmit side blocked
   logic [7:0] tx_q[$];
   int         left = 0;
   int         seed = 57982;
   logic [7:0] next_byte = 8'h00;
   logic       coin;

   initial begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_last_out = 1'b0;
      rx_data_out = 8'h00;
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         tx_ready_out <= 1'b0;
         rx_valid_out <= 1'b0;
         rx_last_out <= 1'b0;
         left = 0;
      end else begin
         coin = 1'($random(seed));
         if (tx_valid_in && tx_ready_out) tx_q.push_back(tx_data_in);
         tx_ready_out <= (mode_in == 2'd0) || (mode_in == 2'd1 && coin);
         if (go_in) begin
            left = int'(len_in);
            next_byte = first_in;
         end
         if (rx_valid_out && rx_ready_in) begin
            left--;
            next_byte++;
         end
         // an offered byte stays put until taken
         if (!rx_valid_out || rx_ready_in) begin
            if (left > 0 && (mode_in != 2'd1 || coin)) begin
               rx_valid_out <= 1'b1;
               rx_data_out <= next_byte;
               rx_last_out <= (left == 1);
            end else begin
               rx_valid_out <= 1'b0;
               rx_last_out <= 1'b0;
               rx_data_out <= ~rx_data_out;
            end
         end
      end
   end
endmodule

`default_nettype wire

// file: test_usb_endpoint_buffer_descriptors.sv
`timescale 1ns/1ps
`default_nettype none

module test_usb_endpoint_buffer_descriptors;
   import usb_desc_pkg::*;

   logic        clock_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        ce_in = 1'b1;
   logic [15:0] descriptor_table_base_in = 16'h0100;
   logic        tok_valid_in = 1'b0;
   token_kind_t tok_kind_in = TOKEN_IN;
   logic [2:0]  tok_ep_in = 3'h0;
   logic        tok_double_in = 1'b0;
   logic        tok_second_in = 1'b0;
   logic        cpu_req_in = 1'b0;
   logic        cpu_we_in = 1'b0;
   logic [9:0]  cpu_addr_in = 10'h000;
   logic [15:0] cpu_wdata_in = 16'h0000;
   logic [7:0]  rx_data_in, tx_data_out;
   logic        rx_valid_in, rx_last_in, rx_ready_out, tx_valid_out, tx_ready_in;
   logic        tok_ready_out, done_out, rx_overflow_out, rx_size_error_out, cpu_ack_out;
   logic [31:0] cpu_rdata_out;
   logic [1:0]  pmode = 2'd0;
   logic        go = 1'b0;
   logic [10:0] plen = 11'h000;
   logic [7:0]  pfirst = 8'h00;
   logic [15:0] mem_m [256];
   int          seed = 57982;
   int          fails = 0;
   int          total_checks = 0;
   int          out_gran[8] = '{0, 0, 0, 0, 1, 1, 1, 1};
   int          out_qty[8] = '{3, 3, 0, 31, 0, 1, 16, 15};
   int          out_n[8] = '{6, 9, 4, 62, 40, 64, 5, 3};

   usb_endpoint_buffer_descriptors u_dut (
      .clock_in, .rst_in, .ce_in, .descriptor_table_base_in, .tok_valid_in, .tok_kind_in,
      .tok_ep_in, .tok_double_in, .tok_second_in, .tok_ready_out, .rx_data_in, .rx_valid_in,
      .rx_last_in, .rx_ready_out, .tx_data_out, .tx_valid_out, .tx_ready_in, .done_out,
      .rx_overflow_out, .rx_size_error_out, .cpu_req_in, .cpu_we_in, .cpu_addr_in,
      .cpu_wdata_in, .cpu_ack_out, .cpu_rdata_out
   );

   usb_line_partner u_partner (
      .clock_in(clock_in), .rst_in(rst_in), .mode_in(pmode), .go_in(go), .len_in(plen),
      .first_in(pfirst), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
      .tx_ready_out(tx_ready_in), .rx_ready_in(rx_ready_out), .rx_data_out(rx_data_in),
      .rx_valid_out(rx_valid_in), .rx_last_out(rx_last_in)
   );

   always #5 clock_in = ~clock_in;

   // ----------------------------------------
   // reference helpers
   // ----------------------------------------
   function automatic int ent(input int ep, input int off);
      return int'(descriptor_table_base_in) + ep * 8 + off;
   endfunction

   function automatic int rx_size(input logic [15:0] e);
      if (e[15]) return (e[14:10] >= 5'h10) ? -1 : (int'(e[14:10]) + 1) * 32;
      return (e[14:10] == 5'h00) ? -1 : int'(e[14:10]) * 2;
   endfunction

   function automatic logic [7:0] byte_at(input int a);
      return a[0] ? mem_m[a / 2][15:8] : mem_m[a / 2][7:0];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      total_checks++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // cpu and token drivers
   // ----------------------------------------
   task automatic cpu(input logic we, input int lb, input logic [15:0] wd, output logic [15:0] rd);
      int n;
      @(posedge clock_in);
      #1;
      cpu_we_in = we;
      cpu_addr_in = 10'(lb * 2);
      cpu_wdata_in = wd;
      cpu_req_in = 1'b1;
      ce_in = lb[2];
      n = 0;
      do begin
         @(posedge clock_in);
         #1;
         ce_in = 1'b1;
         n++;
      end while (cpu_ack_out !== 1'b1 && n < 50);
      cpu_req_in = 1'b0;
      rd = cpu_rdata_out[15:0];
      check(n, lb[2] ? 1 : 2, "cpu answer");
      if (!we) check(cpu_rdata_out[31:16], 0, "upper half");
      if (we) mem_m[lb / 2] = wd;
   endtask

   task automatic wr(input int lb, input logic [15:0] v);
      logic [15:0] d;
      cpu(1'b1, lb, v, d);
   endtask

   task automatic rd_chk(input int lb);
      logic [15:0] v;
      cpu(1'b0, lb, 16'h0000, v);
      check(v, mem_m[lb / 2], "memory word");
   endtask

   task automatic token(input token_kind_t k, input int ep, input logic dbl, input logic sec,
                        input int rxn, input int hold);
      int n;
      @(posedge clock_in);
      #1;
      tok_valid_in = 1'b1;
      tok_kind_in = k;
      tok_ep_in = ep[2:0];
      tok_double_in = dbl;
      tok_second_in = sec;
      @(posedge clock_in);
      #1;
      tok_valid_in = 1'b0;
      check(tok_ready_out, 0, "busy after token");
      go = (k != TOKEN_IN);
      plen = rxn[10:0];
      @(posedge clock_in);
      #1;
      go = 1'b0;
      n = 0;
      while (done_out !== 1'b1 && n < 3000) begin
         if (n == hold && pmode == 2'd2) pmode = 2'd1;
         @(posedge clock_in);
         #1;
         n++;
      end
      check(n >= hold, 1, "done while line blocked");
      check(done_out, 1, "token completion");
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic run_in(input int ep, input logic dbl, input logic sec, input int len, input int hold);
      int off;
      int start;
      off = (dbl && sec) ? 4 : 0;
      start = $random(seed) & 32'h7e;
      wr(ent(ep, off), start[15:0]);
      wr(ent(ep, off + 2), len[15:0]);
      wr(ent(ep, off ^ 4), 16'h00c0);
      wr(ent(ep, (off ^ 4) + 2), 16'h0005);
      for (int k = 0; k < len; k += 2) wr(start + k, 16'($random(seed)));
      u_partner.tx_q.delete();
      pmode = (hold > 0) ? 2'd2 : {1'b0, 1'($random(seed))};
      token(TOKEN_IN, ep, dbl, sec, 0, hold);
      for (int n = 0; n < 300 && u_partner.tx_q.size() < len; n++) @(posedge clock_in);
      repeat (8) @(posedge clock_in);
      #1;
      check(u_partner.tx_q.size(), len, "tx byte count");
      for (int k = 0; k < len && k < u_partner.tx_q.size(); k++) check(u_partner.tx_q[k], byte_at(start + k), "tx byte");
      $display("in test ep %0d len %0d finished", ep, len);
   endtask

   task automatic run_out(input int i);
      int ep;
      int off;
      int start;
      int size;
      int kept;
      int n;
      logic [15:0] e;
      ep = 7 - i;
      n = out_n[i];
      off = (i >= 6) ? ((i == 7) ? 4 : 0) : 4;
      start = $random(seed) & 32'h7e;
      e = {out_gran[i][0], out_qty[i][4:0], 10'($random(seed))};
      size = rx_size(e);
      wr(ent(ep, off), start[15:0]);
      wr(ent(ep, off + 2), e);
      wr(ent(ep, off ^ 4), 16'h00c0);
      wr(ent(ep, (off ^ 4) + 2), 16'h8400);
      pfirst = 8'($random(seed));
      pmode = {1'b0, 1'($random(seed))};
      token(i[0] ? TOKEN_SETUP : TOKEN_OUT, ep, i >= 6, i == 7, n, 0);
      if (size >= 0) check(rx_overflow_out, n > size, "overflow flag");
      check(rx_size_error_out, size < 0, "size flag");
      kept = (size < 0) ? 0 : ((n < size) ? n : size);
      for (int k = 0; k < kept; k++) begin
         if ((start + k) % 2 == 1) mem_m[(start + k) / 2][15:8] = pfirst + 8'(k);
         else mem_m[(start + k) / 2][7:0] = pfirst + 8'(k);
      end
      mem_m[ent(ep, off + 2) / 2] = {e[15:10], 10'(n)};
      rd_chk(ent(ep, off + 2));
      for (int a = start; a < start + n + 2; a += 2) rd_chk(a);
      $display("out test %0d size %0d bytes %0d finished", i, size, n);
   endtask

   initial begin
      repeat (8) @(posedge clock_in);
      check(tok_ready_out, 1, "ready in reset");
      check({done_out, tx_valid_out, rx_ready_out, rx_overflow_out, rx_size_error_out, cpu_ack_out}, 0, "reset");
      #1;
      rst_in = 1'b0;
      for (int a = 0; a < 512; a += 2) wr(a, 16'($random(seed)));
      for (int a = 0; a < 512; a += 34) rd_chk(a);
      $display("memory test finished");
      for (int i = 0; i < 8; i++) begin
         descriptor_table_base_in = i[0] ? 16'h01c0 : 16'h0100;
         run_in(i, i[1], i[2], (i < 2) ? i : ((i == 3) ? 12 : 2 + ($random(seed) & 15)), (i == 3) ? 20 : 0);
      end
      for (int i = 0; i < 8; i++) run_out(i);
      stop_test();
   end

   // whole run needs about 2000 cycles
   initial begin
      #400_000;
      fails++;
      stop_test();
   end
endmodule

`default_nettype wire
